// ---- shared/wso_pkg.sv ----
/*
 * Constants, codes and state types for the weld sequence option block.
 * Assumes an APB master on a 250 MHz pclk and line-cycle ticks from a pin.
 */
package wso_pkg;
	// line cycles per second; all sequence times count line cycles
	localparam int LINE_HZ = 60;

	localparam logic [11:0] OFS_MODE = 12'h000;
	localparam logic [11:0] OFS_POWER = 12'h004;
	localparam logic [11:0] OFS_TURNS = 12'h008;
	localparam logic [11:0] OFS_CCMODE = 12'h00C;
	localparam logic [11:0] OFS_TIME_A = 12'h010;
	localparam logic [11:0] OFS_TIME_B = 12'h014;
	localparam logic [11:0] OFS_STATUS = 12'h018;
	localparam logic [11:0] OFS_SEC = 12'h01C;

	localparam int F_B0 = 0;
	localparam int F_B1 = 8;
	localparam int F_B2 = 16;
	localparam int F_B3 = 24;

	localparam logic [7:0] BEAT_WELD_INH = 8'h04;
	localparam logic [7:0] BEAT_CM5 = 8'h05;
	localparam logic [7:0] BEAT_STEPPER = 8'h06;
	localparam logic [7:0] BEAT_MAX = 8'h06;
	localparam logic [7:0] CM_SINGLE = 8'h00;
	localparam logic [7:0] CM_REPEAT = 8'h01;
	localparam logic [7:0] CM_03 = 8'h03;
	localparam logic [7:0] CM_05 = 8'h05;
	localparam logic [7:0] PO_BLOCK_V3 = 8'h07;
	localparam logic [7:0] PF_AUTO = 8'h00;
	localparam logic [7:0] PF_MAX = 8'h63;
	localparam logic [7:0] PCT_FULL = 8'h63;
	localparam logic [7:0] TR_MIN = 8'h0A;
	localparam logic [7:0] CC_OFF = 8'h00;
	localparam logic [7:0] CC_PRI_AUTO = 8'h0A;
	localparam logic [7:0] CC_PRI_FIX = 8'h0C;
	localparam logic [7:0] CC_PRI_MAX = 8'h13;
	localparam logic [7:0] CC_SEC_AUTO = 8'h1E;
	localparam logic [7:0] CC_SEC_FIX = 8'h20;
	localparam logic [7:0] CC_SEC_MAX = 8'h21;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SQDLY = 3'b001,
		ST_SQZ = 3'b010,
		ST_WELD = 3'b011,
		ST_HOLD = 3'b100,
		ST_BLOCK = 3'b101,
		ST_OFF = 3'b110
	} wso_state_t;

	typedef struct packed {
		logic [7:0] beat;
		logic [7:0] po;
		logic [7:0] cm;
		logic d87;
		logic [7:0] pf;
		logic [7:0] tr;
		logic [7:0] cc;
		logic [7:0] tsd;
		logic [7:0] tsq;
		logic [7:0] twd;
		logic [7:0] thd;
		logic [7:0] toff;
		logic [7:0] tblk;
	} wso_cfg_t;

	typedef struct packed {
		logic pil_s1;
		logic pil_s2;
		logic pil_prev;
		logic es_s1;
		logic es_s2;
		logic es_prev;
		logic inh_s1;
		logic inh_s2;
		logic tk_s1;
		logic tk_s2;
		logic tk_prev;
		wso_cfg_t cfg;
		wso_cfg_t act;
		wso_state_t st;
		logic [7:0] cnt;
		logic v3;
		logic vlv;
		logic dim;
		logic fire;
		logic stp;
		logic [7:0] pfd;
		logic [23:0] isec;
		logic [31:0] prd;
	} wso_st_t;

	localparam wso_cfg_t CFG_RESET = '{d87: 1'b1, tr: TR_MIN, default: 8'h00};
	localparam wso_st_t ST_RESET = '{cfg: CFG_RESET, act: CFG_RESET, st: ST_IDLE, default: '0};
endpackage

// ---- core/wso_core.sv ----
/*
 * Weld sequence option logic: option registers on APB, the sequencer
 * (squeeze delay, squeeze, weld, hold, blocking delay, off) and decodes.
 * Assumes pins are asynchronous to pclk; measured_pf and primary_current
 * come from logic on pclk.
 */
`timescale 1ns/1ps

// Summary of operation
// RULE1: beat code 04: weld inhibit opening in weld jumps straight to hold.
// RULE2: beat code 05 permits cycle mode 05; initiation as non-beat.
// RULE3: beat code 06: momentary estop opening gives a stepper reset pulse.
// RULE4: 87 degree delay code 00 off, 01 on; on after reset.
// RULE5: 87 degree choice acts only in manual power factor mode.
// RULE6: power factor 00 is automatic; nonzero is manual with that value.
// RULE7: operator should use manual power factor 99 for poor factor, low current.
// RULE8: automatic mode scales firing so full current comes at 99 percent.
// RULE9: readout shows power factor measured in last completed weld; code latches it only in automatic power factor mode.
// RULE10: squeeze delay runs valves before first squeeze only, even in repeat.
// RULE11: squeeze delay counts line cycles, sixty per second.
// RULE12: display dims during squeeze delay, normal again in squeeze.
// RULE13: process output 07 turns valve 3 on after blocking delay until next start.
// RULE14: estop opening turns valve 3 off.
// RULE15: blocking delay overlaps off; off shorter is skipped, else shortened.
// RULE16: blocking overlap only when last cycle mode is 00, 01 or 03.
// RULE17: turns ratio accepts only 10 through 255.
// RULE18: primary sensing modes give secondary current as primary times ratio.
// RULE19: even codes regulate and measure; odd codes only measure.
// RULE20: codes 10, 11 primary auto range; code 00 constant current off.
// RULE21: codes 12 to 19 primary fixed ranges 200 A, 500 A, 1 kA, 2 kA.
// RULE22: codes 30, 31 secondary auto range; 32, 33 secondary 2 to 99.99 kA.
// RULE23: started sequence runs to the end; only estop opening aborts it.
// RULE24: out of set ratio, power factor or current mode writes keep old value.
// RULE25: options are sampled at initiation and held until the sequence ends.
module wso_core #(
	parameter int ADDR_W = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic pilot_init,
	input wire logic estop_input,
	input wire logic weld_inhibit_input,
	input wire logic line_sync,
	input wire logic [7:0] measured_pf,
	input wire logic [15:0] primary_current,
	output logic valves_out,
	output logic valve3_out,
	output logic weld_fire,
	output logic dim_display,
	output logic stepper_reset,
	output logic seq_busy,
	output logic delay87_en,
	output logic pf_manual,
	output logic [7:0] pf_value,
	output logic [7:0] full_scale_pct,
	output logic [7:0] pf_display,
	output logic cc_enable,
	output logic cc_regulate,
	output logic cc_secondary,
	output logic cc_autorange,
	output logic [1:0] cc_range_sel,
	output logic [23:0] secondary_current
);
	wso_pkg::wso_st_t q;
	wso_pkg::wso_st_t n;
	logic tick;
	logic init_rise;
	logic es_open;
	logic done;
	logic repeat_go;
	logic blk_ok;
	logic pri_mode;
	logic [11:0] a;
	logic mapped;
	logic [7:0] ccw;

	function automatic logic cc_ok(input logic [7:0] c);
		cc_ok = (c == wso_pkg::CC_OFF) ||
			(c >= wso_pkg::CC_PRI_AUTO && c <= wso_pkg::CC_PRI_MAX) ||
			(c >= wso_pkg::CC_SEC_AUTO && c <= wso_pkg::CC_SEC_MAX);
	endfunction

	////////////////////////////////////////////////////////////////////////
	assign a = 12'(paddr);
	assign tick = q.tk_s2 & ~q.tk_prev; // RULE11
	assign init_rise = q.pil_s2 & ~q.pil_prev;
	assign es_open = q.es_prev & ~q.es_s2;
	assign done = (q.cnt == 8'h00);
	assign repeat_go = (q.act.cm == wso_pkg::CM_REPEAT) && q.pil_s2;
	assign blk_ok = (q.act.cm == wso_pkg::CM_SINGLE) || (q.act.cm == wso_pkg::CM_REPEAT) ||
		(q.act.cm == wso_pkg::CM_03); // RULE16
	assign pri_mode = (q.act.cc >= wso_pkg::CC_PRI_AUTO) && (q.act.cc <= wso_pkg::CC_PRI_MAX);
	assign mapped = (a == wso_pkg::OFS_MODE) || (a == wso_pkg::OFS_POWER) ||
		(a == wso_pkg::OFS_TURNS) || (a == wso_pkg::OFS_CCMODE) ||
		(a == wso_pkg::OFS_TIME_A) || (a == wso_pkg::OFS_TIME_B) ||
		(a == wso_pkg::OFS_STATUS) || (a == wso_pkg::OFS_SEC);
	assign ccw = q.act.cc - wso_pkg::CC_PRI_FIX;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [7:0] nb;
		logic [7:0] ncm;
		nb = q.cfg.beat;
		ncm = q.cfg.cm;
		n = q;
		n.pil_s1 = pilot_init;
		n.pil_s2 = q.pil_s1;
		n.pil_prev = q.pil_s2;
		n.es_s1 = estop_input;
		n.es_s2 = q.es_s1;
		n.es_prev = q.es_s2;
		n.inh_s1 = weld_inhibit_input;
		n.inh_s2 = q.inh_s1;
		n.tk_s1 = line_sync;
		n.tk_s2 = q.tk_s1;
		n.tk_prev = q.tk_s2;
		n.stp = 1'b0;
		if (!done && tick) begin
			n.cnt = q.cnt - 8'h01; // RULE11
		end
		case (q.st)
			wso_pkg::ST_IDLE: begin
				if (init_rise && q.es_s2) begin
					n.act = q.cfg; // RULE25
					n.v3 = 1'b0; // RULE13
					n.cnt = q.cfg.tsd;
					n.st = wso_pkg::ST_SQDLY; // RULE10
				end
			end
			wso_pkg::ST_SQDLY: begin
				if (done) begin
					n.cnt = q.act.tsq;
					n.st = wso_pkg::ST_SQZ;
				end
			end
			wso_pkg::ST_SQZ: begin
				if (done) begin
					n.cnt = q.act.twd;
					n.st = wso_pkg::ST_WELD;
				end
			end
			wso_pkg::ST_WELD: begin
				// any other beat code runs weld to the end
				if (done || (q.act.beat == wso_pkg::BEAT_WELD_INH && !q.inh_s2)) begin // RULE1 RULE2 RULE23
					n.cnt = q.act.thd;
					n.st = wso_pkg::ST_HOLD;
					if (q.act.pf == wso_pkg::PF_AUTO) begin
						n.pfd = measured_pf; // RULE9
					end
					if (pri_mode) begin
						n.isec = 24'(primary_current) * 24'(q.act.tr); // RULE18
					end
				end
			end
			wso_pkg::ST_HOLD: begin
				if (done) begin
					if (blk_ok) begin // RULE16
						n.cnt = q.act.tblk;
						n.st = wso_pkg::ST_BLOCK;
					end else begin
						n.cnt = q.act.toff;
						n.st = wso_pkg::ST_OFF;
					end
				end
			end
			wso_pkg::ST_BLOCK: begin
				if (done) begin
					if (q.act.po == wso_pkg::PO_BLOCK_V3) begin
						n.v3 = 1'b1; // RULE13
					end
					if (q.act.toff > q.act.tblk) begin
						n.cnt = q.act.toff - q.act.tblk; // RULE15
						n.st = wso_pkg::ST_OFF;
					end else if (repeat_go) begin
						n.cnt = q.act.tsq; // RULE10 RULE15
						n.st = wso_pkg::ST_SQZ;
					end else begin
						n.st = wso_pkg::ST_IDLE;
					end
				end
			end
			wso_pkg::ST_OFF: begin
				if (done) begin
					// repeat goes back to squeeze, never to the squeeze delay
					if (repeat_go) begin
						n.cnt = q.act.tsq; // RULE10
						n.st = wso_pkg::ST_SQZ;
					end else begin
						n.st = wso_pkg::ST_IDLE;
					end
				end
			end
			default: begin
				n.st = wso_pkg::ST_IDLE;
			end
		endcase
		// estop wins over every step of the sequence
		if (!q.es_s2) begin
			n.st = wso_pkg::ST_IDLE; // RULE23
			n.cnt = 8'h00;
		end
		if (es_open) begin
			n.v3 = 1'b0; // RULE14
			n.stp = (q.cfg.beat == wso_pkg::BEAT_STEPPER); // RULE3
		end
		n.vlv = (n.st == wso_pkg::ST_SQDLY) || (n.st == wso_pkg::ST_SQZ) ||
			(n.st == wso_pkg::ST_WELD) || (n.st == wso_pkg::ST_HOLD); // RULE10
		n.dim = (n.st == wso_pkg::ST_SQDLY); // RULE12
		n.fire = (n.st == wso_pkg::ST_WELD);

		// apb write: takes effect at the access edge only
		if (psel && penable && pwrite) begin
			case (a)
				wso_pkg::OFS_MODE: begin
					if (pwdata[wso_pkg::F_B0+:8] <= wso_pkg::BEAT_MAX) begin
						nb = pwdata[wso_pkg::F_B0+:8];
					end
					n.cfg.beat = nb;
					n.cfg.po = pwdata[wso_pkg::F_B1+:8];
					ncm = pwdata[wso_pkg::F_B2+:8];
					if (ncm <= wso_pkg::CM_05 && (ncm != wso_pkg::CM_05 || nb == wso_pkg::BEAT_CM5)) begin // RULE2
						n.cfg.cm = ncm;
					end
				end
				wso_pkg::OFS_POWER: begin
					n.cfg.d87 = pwdata[wso_pkg::F_B0]; // RULE4
					if (pwdata[wso_pkg::F_B1+:8] <= wso_pkg::PF_MAX) begin
						n.cfg.pf = pwdata[wso_pkg::F_B1+:8]; // RULE6 RULE24
					end
				end
				wso_pkg::OFS_TURNS: begin
					if (pwdata[wso_pkg::F_B0+:8] >= wso_pkg::TR_MIN) begin
						n.cfg.tr = pwdata[wso_pkg::F_B0+:8]; // RULE17 RULE24
					end
				end
				wso_pkg::OFS_CCMODE: begin
					if (cc_ok(pwdata[wso_pkg::F_B0+:8])) begin
						n.cfg.cc = pwdata[wso_pkg::F_B0+:8]; // RULE24
					end
				end
				wso_pkg::OFS_TIME_A: begin
					n.cfg.tsd = pwdata[wso_pkg::F_B0+:8];
					n.cfg.tsq = pwdata[wso_pkg::F_B1+:8];
					n.cfg.twd = pwdata[wso_pkg::F_B2+:8];
					n.cfg.thd = pwdata[wso_pkg::F_B3+:8];
				end
				wso_pkg::OFS_TIME_B: begin
					n.cfg.toff = pwdata[wso_pkg::F_B0+:8];
					n.cfg.tblk = pwdata[wso_pkg::F_B1+:8];
				end
				default: begin
				end
			endcase
		end

		// read data is captured in the setup cycle, so pready can stay high
		if (psel && !penable) begin
			case (a)
				wso_pkg::OFS_MODE: n.prd = {8'h00, q.cfg.cm, q.cfg.po, q.cfg.beat};
				wso_pkg::OFS_POWER: n.prd = {16'h0000, q.cfg.pf, 7'h00, q.cfg.d87};
				wso_pkg::OFS_TURNS: n.prd = {24'h000000, q.cfg.tr};
				wso_pkg::OFS_CCMODE: n.prd = {24'h000000, q.cfg.cc};
				wso_pkg::OFS_TIME_A: n.prd = {q.cfg.thd, q.cfg.twd, q.cfg.tsq, q.cfg.tsd};
				wso_pkg::OFS_TIME_B: n.prd = {16'h0000, q.cfg.tblk, q.cfg.toff};
				wso_pkg::OFS_STATUS: n.prd = {8'h00, q.cnt, q.pfd, 1'b0, q.dim, q.vlv, q.v3, 1'b0, q.st};
				wso_pkg::OFS_SEC: n.prd = {8'h00, q.isec};
				default: n.prd = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= wso_pkg::ST_RESET;
		end else begin
			q <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign prdata = q.prd;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign valves_out = q.vlv;
	assign valve3_out = q.v3;
	assign weld_fire = q.fire;
	assign dim_display = q.dim;
	assign stepper_reset = q.stp;
	assign seq_busy = (q.st != wso_pkg::ST_IDLE);
	assign pf_manual = (q.act.pf != wso_pkg::PF_AUTO); // RULE6
	assign pf_value = q.act.pf;
	assign delay87_en = pf_manual && q.act.d87; // RULE5
	assign full_scale_pct = pf_manual ? q.act.pf : wso_pkg::PCT_FULL; // RULE8
	assign pf_display = q.pfd;
	assign cc_enable = (q.act.cc != wso_pkg::CC_OFF); // RULE20
	assign cc_regulate = cc_enable && !q.act.cc[0]; // RULE19
	assign cc_secondary = (q.act.cc >= wso_pkg::CC_SEC_AUTO); // RULE22
	assign cc_autorange = cc_enable && (q.act.cc < wso_pkg::CC_PRI_FIX ||
		(cc_secondary && q.act.cc < wso_pkg::CC_SEC_FIX)); // RULE20 RULE22
	assign cc_range_sel = (pri_mode && !cc_autorange) ? ccw[2:1] : 2'b00; // RULE21
	assign secondary_current = q.isec;

	////////////////////////////////////////////////////////////////////////
	AST_BEAT4_ABORT: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
		(q.st == wso_pkg::ST_WELD && q.act.beat == wso_pkg::BEAT_WELD_INH && !q.inh_s2 && q.es_s2)
		|=> (q.st == wso_pkg::ST_HOLD && !weld_fire))
		else $error("weld not cut short by weld inhibit");
	AST_DELAY87_AUTO: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
		(q.act.pf == wso_pkg::PF_AUTO) |-> (!delay87_en && full_scale_pct == 8'h63))
		else $error("87 degree delay or scale wrong in automatic mode");
	AST_DIM_RESTORE: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
		(q.st == wso_pkg::ST_SQZ && $past(q.st) == wso_pkg::ST_SQDLY) |-> (!dim_display && valves_out))
		else $error("display still dim in squeeze");
	AST_REPEAT_NO_DELAY: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
		(q.st == wso_pkg::ST_SQZ && $past(q.st) != wso_pkg::ST_SQDLY && $past(q.st) != wso_pkg::ST_SQZ)
		|-> (q.act.cm == wso_pkg::CM_REPEAT))
		else $error("squeeze entered without squeeze delay outside repeat");
	AST_V3_ESTOP: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
		(q.es_prev && !q.es_s2) |=> (!valve3_out && !seq_busy))
		else $error("valve 3 or sequence survived estop");
	AST_TR_RANGE: assert property (@(posedge pclk) disable iff (!presetn) // RULE17
		(q.cfg.tr >= 8'h0A) && (q.act.tr >= 8'h0A))
		else $error("turns ratio below 10");
	AST_OFF_SHORTENED: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
		(q.st == wso_pkg::ST_OFF && $past(q.st) == wso_pkg::ST_BLOCK)
		|-> (q.cnt == 8'(q.act.toff - q.act.tblk) && q.act.toff > q.act.tblk))
		else $error("off time not reduced by blocking delay");
	AST_ACT_HELD: assert property (@(posedge pclk) disable iff (!presetn) // RULE25
		(seq_busy && $past(seq_busy)) |-> (q.act == $past(q.act)))
		else $error("options changed during a sequence");
	AST_CC_ODD_MONITOR: assert property (@(posedge pclk) disable iff (!presetn) // RULE19
		(cc_enable && q.act.cc[0]) |-> !cc_regulate)
		else $error("monitoring code regulates");
	AST_V3_AFTER_BLOCK: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
		($past(q.st) == wso_pkg::ST_BLOCK && q.st != wso_pkg::ST_BLOCK && $past(q.es_s2) &&
		q.act.po == wso_pkg::PO_BLOCK_V3) |-> valve3_out[*2])
		else $error("valve 3 not on after blocking delay");
	AST_SQDLY_VALVES: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
		(q.st == wso_pkg::ST_SQDLY) |-> (valves_out && dim_display && !weld_fire))
		else $error("squeeze delay without valves or dim display");
	AST_PF_LATCH: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
		($past(q.st) == wso_pkg::ST_WELD && q.st == wso_pkg::ST_HOLD && q.act.pf == wso_pkg::PF_AUTO)
		|-> (pf_display == $past(measured_pf)))
		else $error("power factor readout not taken at end of weld");
	AST_SEC_CURRENT: assert property (@(posedge pclk) disable iff (!presetn) // RULE18
		($past(q.st) == wso_pkg::ST_WELD && q.st == wso_pkg::ST_HOLD && pri_mode)
		|-> (secondary_current == 24'($past(primary_current)) * 24'(q.act.tr)))
		else $error("secondary current not primary times turns ratio");
	AST_STEPPER_PULSE: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
		(q.es_prev && !q.es_s2 && q.cfg.beat == wso_pkg::BEAT_STEPPER) |=> stepper_reset)
		else $error("no stepper reset pulse on estop opening");
	AST_STEPPER_ONE: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
		stepper_reset |=> !stepper_reset)
		else $error("stepper reset pulse longer than one cycle");
	AST_BLOCK_MODE: assert property (@(posedge pclk) disable iff (!presetn) // RULE16
		(q.st == wso_pkg::ST_BLOCK) |-> (q.act.cm == wso_pkg::CM_SINGLE || q.act.cm == wso_pkg::CM_REPEAT ||
		q.act.cm == wso_pkg::CM_03))
		else $error("blocking delay ran in a cycle mode without overlap");
	AST_ESTOP_IDLE: assert property (@(posedge pclk) disable iff (!presetn) // RULE23
		(!q.es_s2) |=> !seq_busy)
		else $error("sequence kept running with estop open");
	AST_WELD_FULL: assert property (@(posedge pclk) disable iff (!presetn) // RULE23
		($past(q.st) == wso_pkg::ST_WELD && q.st == wso_pkg::ST_HOLD && q.act.beat != wso_pkg::BEAT_WELD_INH)
		|-> ($past(q.cnt) == 8'h00))
		else $error("weld cut short outside beat code 04");
	AST_CFG_CODES: assert property (@(posedge pclk) disable iff (!presetn) // RULE24
		(q.cfg.pf <= wso_pkg::PF_MAX) && (q.cfg.beat <= wso_pkg::BEAT_MAX) &&
		(q.cfg.cm <= wso_pkg::CM_05) && cc_ok(q.cfg.cc))
		else $error("option register holds a refused code");
endmodule

// ---- test/wso_plant.sv ----
/*
 * Far side model: line cycle ticks and the weld current sensor.
 * Assumes weld_fire from the core; one tick every TICK pclk cycles.
 */
`timescale 1ns/1ps
module wso_plant #(
	parameter int TICK = 20
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic weld_fire,
	output logic line_sync,
	output logic [7:0] measured_pf,
	output logic [15:0] primary_current
);
	int cnt;
	logic fire_q;
	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			fire_q <= 1'b0;
			measured_pf <= 8'h32;
			primary_current <= 16'h0100;
		end else begin
			cnt <= (cnt == TICK - 1) ? 0 : cnt + 1;
			fire_q <= weld_fire;
			// fresh reading each weld, held until the next weld
			if (weld_fire && !fire_q) begin
				measured_pf <= 8'($urandom_range(1, 99));
				primary_current <= 16'($urandom);
			end
		end
	end
	// wide pulse so the two-stage sync cannot miss it
	assign line_sync = (cnt < 4);
endmodule

// ---- test/tb_top.sv ----
/*
 * Self-checking bench for the weld sequence option core.
 * Assumes wso_pkg, wso_core and the wso_plant far side model.
 */
`timescale 1ns/1ps
module tb_top;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pilot_init, estop_input, weld_inhibit_input, line_sync, d87, man;
	logic [7:0] measured_pf, pf_value, full_scale_pct, pf_display, tr, pf, c;
	logic [15:0] primary_current;
	logic valves_out, valve3_out, weld_fire, dim_display, stepper_reset, seq_busy;
	logic delay87_en, pf_manual, cc_enable, cc_regulate, cc_secondary, cc_autorange;
	logic [1:0] cc_range_sel;
	logic [23:0] secondary_current;
	logic [7:0] codes[$];
	int error_cnt = 0, checks = 0, dim_n = 0, stp_n = 0, fire_n = 0, n;
	////////////////////////////////////////////////////////////////////////////////
	wso_core wso_core_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.pilot_init, .estop_input, .weld_inhibit_input, .line_sync, .measured_pf, .primary_current,
		.valves_out, .valve3_out, .weld_fire, .dim_display, .stepper_reset, .seq_busy, .delay87_en,
		.pf_manual, .pf_value, .full_scale_pct, .pf_display, .cc_enable, .cc_regulate, .cc_secondary,
		.cc_autorange, .cc_range_sel, .secondary_current);
	wso_plant wso_plant_i (.pclk, .presetn, .weld_fire, .line_sync, .measured_pf, .primary_current);
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	always @(posedge dim_display) dim_n++;
	always @(posedge stepper_reset) stp_n++;
	always @(posedge weld_fire) fire_n++;
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value at %0t: %s got %h want %h", $time, m, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic sig(input int k);
		case (k)
			0: return seq_busy;
			1: return dim_display;
			2: return weld_fire;
			default: return valve3_out;
		endcase
	endfunction
	// bounded wait; n holds the cycles it took
	task automatic wt(input int k, input logic v);
		n = 0;
		while (sig(k) !== v && n < 3000) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 3000) chk(k, 32'hFF, "wait ran out");
	endtask
	task automatic start();
		@(posedge pclk);
		pilot_init <= 1'b1;
		wt(0, 1'b1);
	endtask
	task automatic finish_seq();
		wt(0, 1'b0);
		pilot_init <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask
	task automatic wrap_up();
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (60000) @(posedge pclk);
		error_cnt++;
		wrap_up();
	end
	initial begin
		void'($urandom(32'h043A));
		{psel, penable, pwrite, paddr, pwdata, pilot_init, presetn} = '0;
		estop_input = 1'b1;
		weld_inhibit_input = 1'b1;
		for (int k = 0; k < 34; k++) if (k == 0 || k >= 10 && k <= 19 || k >= 30) codes.push_back(8'(k));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		apb(0, wso_pkg::OFS_POWER, 0);
		chk(rd, 32'h00000001, "power reset");
		chk(full_scale_pct, 8'h63, "auto full scale");
		apb(1, wso_pkg::OFS_TURNS, 32'h00000009);
		apb(0, wso_pkg::OFS_TURNS, 0);
		chk(rd, 32'h0000000A, "turns below range kept");
		apb(0, 12'h020, 0);
		chk(rd, 32'h00000000, "unmapped read data");
		chk(err, 1'b1, "unmapped read error");
		apb(1, wso_pkg::OFS_MODE, 32'h00050000);
		apb(0, wso_pkg::OFS_MODE, 0);
		chk(rd, 32'h00000000, "cycle mode 5 refused");
		apb(1, wso_pkg::OFS_MODE, 32'h00050005);
		apb(0, wso_pkg::OFS_MODE, 0);
		chk(rd, 32'h00050005, "cycle mode 5 allowed");
		apb(1, wso_pkg::OFS_MODE, 0);
		apb(1, wso_pkg::OFS_TIME_A, 32'h00020000);
		foreach (codes[i]) begin
			c = codes[i];
			tr = 8'($urandom_range(10, 255));
			pf = (i % 3 == 0) ? 8'h00 : (i == 1 ? 8'h63 : 8'($urandom_range(1, 99)));
			d87 = 1'($urandom);
			man = (pf != 8'h00);
			apb(1, wso_pkg::OFS_TURNS, {24'h0, tr});
			apb(1, wso_pkg::OFS_POWER, {16'h0, pf, 7'h0, d87});
			apb(1, wso_pkg::OFS_CCMODE, {24'h0, c});
			start();
			// written mid-sequence, must wait for the next start
			apb(1, wso_pkg::OFS_POWER, 32'h00000501);
			finish_seq();
			chk(pf_manual, man, "manual pf");
			chk(delay87_en, man & d87, "87 delay");
			chk(full_scale_pct, man ? pf : 8'h63, "full scale");
			if (man) chk(pf_value, pf, "pf value");
			else chk(pf_display, measured_pf, "pf readout");
			chk(cc_enable, c != 0, "cc on");
			chk(cc_regulate, c != 0 && !c[0], "cc regulate");
			chk(cc_secondary, c >= 30, "cc secondary");
			chk(cc_autorange, c inside {10, 11, 30, 31}, "autorange");
			chk(cc_range_sel, (c >= 12 && c <= 19) ? 2'((c - 12) >> 1) : 2'b00, "range");
			if (c >= 10 && c <= 19) begin
				chk(secondary_current, 24'(primary_current) * tr, "secondary");
				apb(0, wso_pkg::OFS_SEC, 0);
				chk(rd, 32'(primary_current) * tr, "secondary register");
			end
		end
		apb(1, wso_pkg::OFS_POWER, 32'h00006401);
		apb(0, wso_pkg::OFS_POWER, 0);
		chk(rd, 32'h00000501, "pf 100 refused");
		apb(1, wso_pkg::OFS_CCMODE, 32'h00000014);
		apb(0, wso_pkg::OFS_CCMODE, 0);
		chk(rd, 32'h00000021, "cc 20 refused");
		apb(1, wso_pkg::OFS_TIME_A, 32'h00010103);
		apb(1, wso_pkg::OFS_MODE, 32'h00010000);
		dim_n = 0;
		fire_n = 0;
		start();
		wt(1, 1'b0);
		chk(n > 40 && n <= 62, 1, "squeeze delay length");
		chk(valves_out, 1, "valves in squeeze");
		repeat (300) @(posedge pclk);
		chk(dim_n, 1, "one squeeze delay in repeat");
		chk(fire_n > 1, 1, "repeat ran");
		// repeat only stops once the pilot opens
		pilot_init <= 1'b0;
		finish_seq();
		apb(1, wso_pkg::OFS_MODE, 32'h00000700);
		apb(1, wso_pkg::OFS_TIME_A, 32'h00010000);
		apb(1, wso_pkg::OFS_TIME_B, 32'h00000205);
		start();
		wt(3, 1'b1);
		wt(0, 1'b0);
		chk(n > 40 && n <= 62, 1, "off minus blocking");
		chk(valve3_out, 1, "valve 3 held after end");
		apb(0, wso_pkg::OFS_STATUS, 0);
		chk(rd & 32'h00FF00FF, 32'h00000010, "status idle with valve 3");
		finish_seq();
		apb(1, wso_pkg::OFS_TIME_B, 32'h00000201);
		start();
		repeat (2) @(posedge pclk);
		chk(valve3_out, 0, "valve 3 cleared by start");
		wt(3, 1'b1);
		wt(0, 1'b0);
		chk(n <= 3, 1, "short off skipped");
		finish_seq();
		estop_input <= 1'b0;
		repeat (6) @(posedge pclk);
		chk(valve3_out, 0, "estop clears valve 3");
		chk(stp_n, 0, "no stepper pulse outside beat 6");
		estop_input <= 1'b1;
		apb(1, wso_pkg::OFS_MODE, 32'h00020700);
		start();
		finish_seq();
		chk(valve3_out, 0, "no blocking for cycle mode 2");
		apb(1, wso_pkg::OFS_MODE, 32'h00030700);
		start();
		finish_seq();
		chk(valve3_out, 1, "blocking runs for cycle mode 3");
		apb(1, wso_pkg::OFS_MODE, 32'h00000004);
		apb(1, wso_pkg::OFS_TIME_A, 32'h020A0000);
		start();
		wt(2, 1'b1);
		repeat ($urandom_range(5, 100)) @(posedge pclk);
		weld_inhibit_input <= 1'b0;
		wt(2, 1'b0);
		chk(n <= 6, 1, "weld cut short");
		chk({seq_busy, valves_out}, 2'b11, "hold follows");
		weld_inhibit_input <= 1'b1;
		finish_seq();
		apb(1, wso_pkg::OFS_MODE, 32'h00000006);
		start();
		repeat (20) @(posedge pclk);
		estop_input <= 1'b0;
		wt(0, 1'b0);
		chk(n <= 6, 1, "estop aborts");
		repeat (4) @(posedge pclk);
		chk(stp_n, 1, "stepper reset pulse");
		estop_input <= 1'b1;
		finish_seq();
		wrap_up();
	end
endmodule
